// ===== logic/ssr_cfg.svh
// constants for the status reporting block: register indices, bits, limits
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH
`define SSR_IDX_OPER_COND     4'h0
`define SSR_IDX_OPER_EVENT    4'h1
`define SSR_IDX_OPER_ENABLE   4'h2
`define SSR_IDX_OPER_RISE     4'h3
`define SSR_IDX_OPER_FALL     4'h4
`define SSR_IDX_QUES_COND     4'h5
`define SSR_IDX_QUES_EVENT    4'h6
`define SSR_IDX_QUES_ENABLE   4'h7
`define SSR_IDX_QUES_RISE     4'h8
`define SSR_IDX_QUES_FALL     4'h9
`define SSR_IDX_TEMP_COMP     4'hA
`define SSR_OPER_CAL_BIT      0
`define SSR_OPER_TRIG_BIT     3
`define SSR_OPER_MEAS_BIT     4
`define SSR_QUES_VOLT_BIT     0
`define SSR_QUES_TEMP_BIT     4
`define SSR_QUES_CAL_BIT      8
`define SSR_OPER_USED_MASK    16'h0019
`define SSR_QUES_USED_MASK    16'h0111
`define SSR_DRIFT_COMP_LIMIT  30
`define SSR_DRIFT_RAW_LIMIT   4
`define SSR_RESET_MASK        16'h0000
`define SSR_RESET_FILTER_RISE 16'hFFFF
`define SSR_RESET_FILTER_FALL 16'h0000
`endif

// ===== logic/ssr_pkg.sv
// types for the status reporting block
package ssr_pkg;
    typedef logic [15:0] ssr_word_t;
    typedef enum logic [1:0] {
        SSR_ACC_IDLE,
        SSR_ACC_READ,
        SSR_ACC_WRITE
    } ssr_acc_t;
endpackage

// ===== logic/ssr_status_group.sv
// one status group: condition, transition filters, event latch, mask
`timescale 1ns/1ns
`default_nettype none
`include "ssr_cfg.svh"
module ssr_status_group
    import ssr_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] cond,
    input  wire logic [WIDTH-1:0] rise_filter,
    input  wire logic [WIDTH-1:0] fall_filter,
    input  wire logic [WIDTH-1:0] enable_mask,
    input  wire logic             clear_event,
    output logic      [WIDTH-1:0] event_latch,
    output logic                  summary
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] evt;
        logic             sum;
    } ssr_grp_state_t;

    ssr_grp_state_t state;
    ssr_grp_state_t next_state;
    logic [WIDTH-1:0] hits;

    always_comb begin
        next_state = state;
        next_state.prev = cond;
        hits = (cond & ~state.prev & rise_filter)
             | (~cond & state.prev & fall_filter);
        // a hit in the clearing cycle survives the clear
        next_state.evt = (clear_event ? '0 : state.evt) | hits;
        next_state.sum = |(next_state.evt & enable_mask);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign event_latch = state.evt;
    assign summary     = state.sum;
endmodule
`default_nettype wire

// ===== logic/ssr_drift_check.sv
// sensor temperature drift window against the calibration temperature
`timescale 1ns/1ns
`default_nettype none
`include "ssr_cfg.svh"
module ssr_drift_check
    import ssr_pkg::*;
#(
    parameter int TW = 8
) (
    input  wire logic signed [TW-1:0] temp_now,
    input  wire logic signed [TW-1:0] temp_cal,
    input  wire logic                 comp_active,
    output logic                      drift
);
    logic signed [TW:0] diff;
    logic        [TW:0] mag;
    logic        [TW:0] limit;

    always_comb begin
        diff  = {temp_now[TW-1], temp_now} - {temp_cal[TW-1], temp_cal};
        mag   = diff[TW] ? (TW+1)'(-diff) : diff;
        limit = comp_active ? (TW+1)'(`SSR_DRIFT_COMP_LIMIT)
                            : (TW+1)'(`SSR_DRIFT_RAW_LIMIT);
        drift = mag > limit;
    end
endmodule
`default_nettype wire

// ===== logic/ssr_status_top.sv
// status reporting block: operation and questionable groups, register port
// What this block does
// - operation condition bit 0 high while a calibration runs
// - operation condition bit 3 high while waiting for trigger
// - operation condition bit 4 high while measuring
// - operation condition reads live, unused bits read zero
// - enabled rising filter latches event on a 0 to 1 change
// - enabled falling filter latches event on a 1 to 0 change
// - enabled operation event raises the operation summary bit
// - operation event latch reads back as 16 bits
// - enabled questionable event raises the questionable summary bit
// - questionable event latch reads back as 16 bits
// - preset clears both enable masks
// - preset also empties the error queue
// - questionable bit 0 high while a supply is out of range
// - questionable bit 4 high while sensor temperature drifted
// - questionable bit 8 high while sensor needs calibration or zero
// - compensation on: drift flag beyond 30 degrees either way
// - compensation off or absent: drift flag beyond 4 degrees
// - questionable condition reads live, unused bits read zero
// - compensation defaults on at power-up and on sensor insertion
`timescale 1ns/1ns
`default_nettype none
`include "ssr_cfg.svh"
module ssr_status_top
    import ssr_pkg::*;
#(
    parameter int TW = 8
) (
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    input  wire logic                 CALIBRATING,
    input  wire logic                 WAIT_TRIGGER,
    input  wire logic                 MEASURING,
    input  wire logic                 SUPPLY_FAULT,
    input  wire logic                 NEEDS_CAL,
    input  wire logic                 SENSOR_HAS_COMP,
    input  wire logic                 SENSOR_INSERTED,
    input  wire logic signed [TW-1:0] SENSOR_TEMP,
    input  wire logic signed [TW-1:0] CAL_TEMP,
    input  wire logic                 REG_RD,
    input  wire logic                 REG_WR,
    input  wire logic                 PRESET,
    input  wire logic [3:0]           REG_IDX,
    input  wire logic [15:0]          REG_WDATA,
    output logic      [15:0]          REG_RDATA,
    output logic                      REG_ACK,
    output logic                      OPER_SUMMARY,
    output logic                      QUES_SUMMARY,
    output logic                      ERRQ_CLEAR
);
    typedef struct packed {
        ssr_word_t oper_cond;
        ssr_word_t ques_cond;
        ssr_word_t oper_enable_mask;
        ssr_word_t oper_rising_edge_filter;
        ssr_word_t oper_falling_edge_filter;
        ssr_word_t ques_enable_mask;
        ssr_word_t ques_rising_edge_filter;
        ssr_word_t ques_falling_edge_filter;
        logic      temp_comp;
        ssr_word_t rdata;
        logic      ack;
        logic      errq_clear;
        ssr_acc_t  acc;
    } ssr_top_state_t;

    ssr_top_state_t state;
    ssr_top_state_t next_state;
    ssr_word_t      oper_event;
    ssr_word_t      ques_event;
    logic           oper_sum;
    logic           ques_sum;
    logic           drift;
    // clear on the taking edge: a later clear would drop hits latched meanwhile
    logic           oper_clr;
    logic           ques_clr;

    ssr_drift_check #(
        .TW(TW)
    ) u_drift (
        .temp_now    (SENSOR_TEMP),
        .temp_cal    (CAL_TEMP),
        // sensors without a table always run uncompensated
        .comp_active (state.temp_comp & SENSOR_HAS_COMP),
        .drift       (drift)
    );

    ssr_status_group #(
        .WIDTH(16)
    ) u_oper (
        .clk         (CLK),
        .reset       (RESET),
        .cond        (state.oper_cond),
        .rise_filter (state.oper_rising_edge_filter),
        .fall_filter (state.oper_falling_edge_filter),
        .enable_mask (state.oper_enable_mask),
        .clear_event (oper_clr),
        .event_latch (oper_event),
        .summary     (oper_sum)
    );

    ssr_status_group #(
        .WIDTH(16)
    ) u_ques (
        .clk         (CLK),
        .reset       (RESET),
        .cond        (state.ques_cond),
        .rise_filter (state.ques_rising_edge_filter),
        .fall_filter (state.ques_falling_edge_filter),
        .enable_mask (state.ques_enable_mask),
        .clear_event (ques_clr),
        .event_latch (ques_event),
        .summary     (ques_sum)
    );

    always_comb begin
        next_state = state;
        next_state.ack        = 1'b0;
        next_state.errq_clear = 1'b0;
        oper_clr              = 1'b0;
        ques_clr              = 1'b0;
        next_state.acc        = SSR_ACC_IDLE;

        next_state.oper_cond = '0;
        next_state.oper_cond[`SSR_OPER_CAL_BIT]  = CALIBRATING;
        next_state.oper_cond[`SSR_OPER_TRIG_BIT] = WAIT_TRIGGER;
        next_state.oper_cond[`SSR_OPER_MEAS_BIT] = MEASURING;
        next_state.ques_cond = '0;
        next_state.ques_cond[`SSR_QUES_VOLT_BIT] = SUPPLY_FAULT;
        next_state.ques_cond[`SSR_QUES_TEMP_BIT] = drift;
        next_state.ques_cond[`SSR_QUES_CAL_BIT]  = NEEDS_CAL;

        if (SENSOR_INSERTED) begin
            next_state.temp_comp = 1'b1;
        end

        if (PRESET) begin
            next_state.oper_enable_mask = `SSR_RESET_MASK;
            next_state.ques_enable_mask = `SSR_RESET_MASK;
            next_state.errq_clear = 1'b1;
            next_state.ack        = 1'b1;
        end else if (REG_WR) begin
            next_state.acc = SSR_ACC_WRITE;
            next_state.ack = 1'b1;
            case (REG_IDX)
                `SSR_IDX_OPER_ENABLE: begin
                    next_state.oper_enable_mask = REG_WDATA;
                end
                `SSR_IDX_OPER_RISE: begin
                    next_state.oper_rising_edge_filter = REG_WDATA;
                end
                `SSR_IDX_OPER_FALL: begin
                    next_state.oper_falling_edge_filter = REG_WDATA;
                end
                `SSR_IDX_QUES_ENABLE: begin
                    next_state.ques_enable_mask = REG_WDATA;
                end
                `SSR_IDX_QUES_RISE: begin
                    next_state.ques_rising_edge_filter = REG_WDATA;
                end
                `SSR_IDX_QUES_FALL: begin
                    next_state.ques_falling_edge_filter = REG_WDATA;
                end
                `SSR_IDX_TEMP_COMP: begin
                    next_state.temp_comp = REG_WDATA[0];
                end
                default: begin
                    // read-only or unmapped: write ignored
                end
            endcase
        end else if (REG_RD) begin
            next_state.acc = SSR_ACC_READ;
            next_state.ack = 1'b1;
            case (REG_IDX)
                `SSR_IDX_OPER_COND: begin
                    next_state.rdata = state.oper_cond
                                     & `SSR_OPER_USED_MASK;
                end
                `SSR_IDX_OPER_EVENT: begin
                    next_state.rdata    = oper_event;
                    oper_clr         = 1'b1;
                end
                `SSR_IDX_OPER_ENABLE: begin
                    next_state.rdata = state.oper_enable_mask;
                end
                `SSR_IDX_OPER_RISE: begin
                    next_state.rdata = state.oper_rising_edge_filter;
                end
                `SSR_IDX_OPER_FALL: begin
                    next_state.rdata = state.oper_falling_edge_filter;
                end
                `SSR_IDX_QUES_COND: begin
                    next_state.rdata = state.ques_cond
                                     & `SSR_QUES_USED_MASK;
                end
                `SSR_IDX_QUES_EVENT: begin
                    next_state.rdata    = ques_event;
                    ques_clr         = 1'b1;
                end
                `SSR_IDX_QUES_ENABLE: begin
                    next_state.rdata = state.ques_enable_mask;
                end
                `SSR_IDX_QUES_RISE: begin
                    next_state.rdata = state.ques_rising_edge_filter;
                end
                `SSR_IDX_QUES_FALL: begin
                    next_state.rdata = state.ques_falling_edge_filter;
                end
                `SSR_IDX_TEMP_COMP: begin
                    next_state.rdata = {15'h0000, state.temp_comp};
                end
                default: begin
                    next_state.rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state <= '0;
            state.oper_rising_edge_filter <= `SSR_RESET_FILTER_RISE;
            state.ques_rising_edge_filter <= `SSR_RESET_FILTER_RISE;
            state.oper_falling_edge_filter <= `SSR_RESET_FILTER_FALL;
            state.ques_falling_edge_filter <= `SSR_RESET_FILTER_FALL;
            state.temp_comp <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign REG_RDATA    = state.rdata;
    assign REG_ACK      = state.ack;
    assign OPER_SUMMARY = oper_sum;
    assign QUES_SUMMARY = ques_sum;
    assign ERRQ_CLEAR   = state.errq_clear;
endmodule
`default_nettype wire

// ===== verif/ssr_status_chk.sv
// port assertions for the status reporting block
`timescale 1ns/1ns
`default_nettype none
module ssr_chk
    import ssr_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        CALIBRATING,
    input wire logic        REG_RD,
    input wire logic        REG_WR,
    input wire logic        PRESET,
    input wire logic [3:0]  REG_IDX,
    input wire logic [15:0] REG_RDATA,
    input wire logic        REG_ACK,
    input wire logic        OPER_SUMMARY,
    input wire logic        QUES_SUMMARY,
    input wire logic        ERRQ_CLEAR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    wire logic any_req = REG_RD || REG_WR || PRESET;
    sequence rd_at(logic [3:0] i);
        REG_RD && !REG_WR && !PRESET && REG_IDX == i;
    endsequence
    // condition register lags the input by one edge
    sequence cal_read;
        CALIBRATING [*2] ##0 rd_at(4'h0);
    endsequence
    sequence preset_quiet;
        PRESET ##1 !REG_WR [*2];
    endsequence
    chk_ack_follows: assert property (any_req |=> REG_ACK)
        else $error("no ack after request");
    chk_ack_cause: assert property (REG_ACK |-> $past(any_req))
        else $error("ack without request");
    chk_errq_pulse: assert property (PRESET |=> ERRQ_CLEAR)
        else $error("preset gave no queue clear");
    chk_errq_cause: assert property (ERRQ_CLEAR |-> $past(PRESET))
        else $error("queue clear without preset");
    chk_cal_bit: assert property (cal_read |=> REG_RDATA[0])
        else $error("calibration bit not read back");
    chk_oper_unused: assert property (rd_at(4'h0) |=>
        (REG_RDATA & 16'hFFE6) == 16'h0000)
        else $error("operation unused bits set");
    chk_ques_unused: assert property (rd_at(4'h5) |=>
        (REG_RDATA & 16'hFEEE) == 16'h0000)
        else $error("questionable unused bits set");
    chk_mask_preset: assert property (preset_quiet |=>
        !OPER_SUMMARY && !QUES_SUMMARY)
        else $error("summary survives preset");
    chk_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without read");
endmodule
bind ssr_status_top ssr_chk u_chk (.CLK(CLK), .RESET(RESET),
    .CALIBRATING(CALIBRATING), .REG_RD(REG_RD), .REG_WR(REG_WR),
    .PRESET(PRESET), .REG_IDX(REG_IDX), .REG_RDATA(REG_RDATA),
    .REG_ACK(REG_ACK), .OPER_SUMMARY(OPER_SUMMARY),
    .QUES_SUMMARY(QUES_SUMMARY), .ERRQ_CLEAR(ERRQ_CLEAR));
`default_nettype wire

// ===== verif/ssr_host_model.sv
// remote bus controller model issuing register requests
`timescale 1ns/1ns
`default_nettype none
module ssr_host_model (
    input  wire logic  CLK,
    input  wire logic  REG_ACK,
    output logic       REG_RD,
    output logic       REG_WR,
    output logic       PRESET,
    output logic [3:0] REG_IDX,
    output logic [15:0] REG_WDATA
);
    initial begin
        {PRESET, REG_WR, REG_RD} = 3'b000;
        REG_IDX = 4'h0;
        REG_WDATA = 16'h0000;
    end
    // k picks preset, write or read; one-edge pulse, else it is taken twice
    task automatic req(input logic [2:0] k, input logic [3:0] i,
                       input logic [15:0] d, output logic ok);
        int n;
        @(posedge CLK);
        {PRESET, REG_WR, REG_RD} <= k;
        REG_IDX <= i;
        REG_WDATA <= d;
        @(posedge CLK);
        {PRESET, REG_WR, REG_RD} <= 3'b000;
        // index and data stay put until the acknowledge is seen
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (REG_ACK !== 1'b1 && n < 4);
        ok = (REG_ACK === 1'b1);
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_scpi_status_reporting.sv
// self-checking bench for the status reporting block
`timescale 1ns/1ns
`default_nettype none
module tb_scpi_status_reporting
    import ssr_pkg::*;
;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic cal = 1'b0, trg = 1'b0, meas = 1'b0, sup = 1'b0, ncal = 1'b0;
    logic has_comp = 1'b1, ins = 1'b0;
    logic signed [7:0] temp = 8'sh00, cal_t = 8'sh14;
    wire logic rd_s, wr_s, pre, ack, osum, qsum, errq;
    wire logic [3:0] idx;
    wire logic [15:0] wd, rdat;
    int fails = 0, n_compared = 0;
    always #20 CLK = ~CLK;
    ssr_status_top uut (.CLK(CLK), .RESET(RESET), .CALIBRATING(cal),
        .WAIT_TRIGGER(trg), .MEASURING(meas), .SUPPLY_FAULT(sup),
        .NEEDS_CAL(ncal), .SENSOR_HAS_COMP(has_comp),
        .SENSOR_INSERTED(ins), .SENSOR_TEMP(temp), .CAL_TEMP(cal_t),
        .REG_RD(rd_s), .REG_WR(wr_s), .PRESET(pre), .REG_IDX(idx),
        .REG_WDATA(wd), .REG_RDATA(rdat), .REG_ACK(ack),
        .OPER_SUMMARY(osum), .QUES_SUMMARY(qsum), .ERRQ_CLEAR(errq));
    ssr_host_model host (.CLK(CLK), .REG_ACK(ack), .REG_RD(rd_s),
        .REG_WR(wr_s), .PRESET(pre), .REG_IDX(idx), .REG_WDATA(wd));
    task automatic chk(input string nm, input ssr_word_t got, exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic op(input logic [2:0] k, input logic [3:0] i,
                      input ssr_word_t d);
        logic ok;
        host.req(k, i, d, ok);
        chk("ack", 16'(ok), 16'h0001);
    endtask
    task automatic rchk(input logic [3:0] i, input ssr_word_t e,
                        input string nm);
        op(3'b001, i, 16'h0000);
        chk(nm, rdat, e);
    endtask
    task automatic t_reset();
        rchk(4'h3, 16'hFFFF, "oper rise");
        rchk(4'h9, 16'h0000, "ques fall");
        rchk(4'h2, 16'h0000, "oper mask");
        rchk(4'hA, 16'h0001, "temp comp");
        rchk(4'hB, 16'h0000, "unmapped");
        op(3'b010, 4'h0, 16'hFFFF);
        rchk(4'h0, 16'h0000, "oper cond ro");
        $display("test reset done");
    endtask
    task automatic t_oper();
        op(3'b010, 4'h2, 16'h0010);
        @(posedge CLK);
        cal <= 1'b1;
        trg <= 1'b1;
        meas <= 1'b1;
        repeat (3) @(posedge CLK);
        chk("oper summary", 16'(osum), 16'h0001);
        rchk(4'h0, 16'h0019, "oper cond");
        rchk(4'h1, 16'h0019, "oper event");
        repeat (3) @(posedge CLK);
        chk("oper summary off", 16'(osum), 16'h0000);
        rchk(4'h1, 16'h0000, "oper event read");
        trg <= 1'b0;
        rchk(4'h0, 16'h0011, "oper cond trig");
        meas <= 1'b0;
        rchk(4'h0, 16'h0001, "oper cond meas");
        $display("test operation done");
    endtask
    task automatic t_ques();
        op(3'b010, 4'h8, 16'h0000);
        op(3'b010, 4'h9, 16'h0100);
        op(3'b010, 4'h7, 16'h0100);
        @(posedge CLK);
        sup <= 1'b1;
        ncal <= 1'b1;
        repeat (3) @(posedge CLK);
        rchk(4'h5, 16'h0101, "ques cond");
        rchk(4'h6, 16'h0000, "ques event rise");
        sup <= 1'b0;
        ncal <= 1'b0;
        repeat (3) @(posedge CLK);
        chk("ques summary", 16'(qsum), 16'h0001);
        rchk(4'h6, 16'h0100, "ques event fall");
        $display("test questionable done");
    endtask
    // calibration temperature is 20 degrees throughout
    task automatic dstep(input logic h, input logic signed [7:0] t,
                         input logic e);
        @(posedge CLK);
        has_comp <= h;
        temp <= t;
        repeat (3) @(posedge CLK);
        rchk(4'h5, {11'h000, e, 4'h0}, "drift flag");
    endtask
    task automatic t_drift();
        dstep(1'b1, 8'sd50, 1'b0);
        dstep(1'b1, 8'sd51, 1'b1);
        dstep(1'b1, -8'sd10, 1'b0);
        dstep(1'b1, -8'sd11, 1'b1);
        dstep(1'b0, 8'sd24, 1'b0);
        dstep(1'b0, 8'sd25, 1'b1);
        op(3'b010, 4'hA, 16'h0000);
        dstep(1'b1, 8'sd15, 1'b1);
        dstep(1'b1, 8'sd16, 1'b0);
        @(posedge CLK);
        ins <= 1'b1;
        @(posedge CLK);
        ins <= 1'b0;
        dstep(1'b1, 8'sd25, 1'b0);
        $display("test drift done");
    endtask
    task automatic t_preset();
        op(3'b010, 4'h2, 16'hFFFF);
        op(3'b010, 4'h7, 16'hFFFF);
        // latch an enabled event so the preset has a summary to silence
        trg <= 1'b1;
        repeat (3) @(posedge CLK);
        chk("oper summary armed", 16'(osum), 16'h0001);
        op(3'b100, 4'h0, 16'h0000);
        chk("queue clear", 16'(errq), 16'h0001);
        @(posedge CLK);
        chk("oper summary preset", 16'(osum), 16'h0000);
        rchk(4'h2, 16'h0000, "oper mask preset");
        rchk(4'h7, 16'h0000, "ques mask preset");
        $display("test preset done");
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge CLK);
        fails++;
        results();
    end
    initial begin
        repeat (12) @(posedge CLK);
        RESET <= 1'b0;
        t_reset();
        t_oper();
        t_ques();
        t_drift();
        t_preset();
        results();
    end
endmodule
`default_nettype wire
